//--- rtl/aoi_adc_map.svh
// Constants for the converter control core: channel codes, CONTROL_STATUS_PORT words, field positions, reset values
`ifndef AOI_ADC_MAP_SVH
`define AOI_ADC_MAP_SVH

`define AOI_SAMPLE_W        12
`define AOI_CHAN_W          5
`define AOI_CHAN_TSD        5'h11
`define AOI_CHAN_RECAL      5'h1F
`define AOI_CSR_DATA_W      32
`define AOI_CSR_ENABLE      1'h0
`define AOI_CSR_STATUS      1'h1
`define AOI_BIT_EOP         0
`define AOI_BIT_LOCK        1
`define AOI_ENABLE_RST      1'h0
`define AOI_STATUS_RST      1'h0
`define AOI_SYNC_RST        1'h0

`endif

//--- rtl/aoi_pkg.sv
// Types shared by the converter control core
package aoi_pkg;

   typedef enum logic [1:0] {
      AOI_IDLE = 2'b00,
      AOI_CONV = 2'b01,
      AOI_RESP = 2'b10
   } aoi_state_type;

endpackage : aoi_pkg

//--- rtl/aoi_adc_core_if.sv
// Converter control core: command sink, response and threshold sources, CONTROL_STATUS_PORT slave and interrupt
`timescale 1ns/1ns
`default_nettype none
`include "aoi_adc_map.svh"

// Functional notes
// [RULE1] Results leave on a stream with no ready input, valid rising as soon as a result exists.
// [RULE2] The result sink must keep up or buffer, since nothing here holds a result back.
// [RULE3] Each result carries a 5-bit channel tag: 0..16 analog inputs, 17 the temperature sensor.
// [RULE4] Result data is 12 bits for one converter and 24 bits, one sample each, for two.
// [RULE5] Start and end of packet on each result are copied from the command that asked for it.
// [RULE6] Limit violations leave on their own stream without ready, with valid and the channel tag.
// [RULE7] The violation data bit is 1 above the upper limit and 0 below the lower limit.
// [RULE8] The control/status port is a word-addressed slave with read, write and 32-bit data buses.
// [RULE9] One interrupt request output signals pending events.
// [RULE10] All logic runs on the one peripheral clock.
// [RULE11] One active-low reset resets all of the logic.
// [RULE12] The converter clock comes from the first output of a dedicated PLL outside this core.
// [RULE13] The lock indication of that PLL reaches the one-bit lock input.
// [RULE14] A command is taken in the cycle where its valid and ready are both high.
// [RULE15] The interrupt rises only when an event bit and its enable are both set; status stays visible.
module aoi_adc_core_if #(
   parameter int DUAL = 0
) (
   input  wire logic                                   core_clk,
   input  wire logic                                   rstN,
   input  wire logic                                   clkEn,
   // Command stream
   input  wire logic                                   cmdValid,
   output logic                                        cmdReady,
   input  wire logic [`AOI_CHAN_W-1:0]                 cmdChannel,
   input  wire logic                                   cmdSop,
   input  wire logic                                   cmdEop,
   // Hard converter handshake and lock
   input  wire logic                                   pllLocked,
   output logic                                        convStart,
   output logic [`AOI_CHAN_W-1:0]                      convChannel,
   input  wire logic                                   convDone,
   input  wire logic [`AOI_SAMPLE_W*(DUAL+1)-1:0]      convData,
   // Limits for violation checks
   input  wire logic [`AOI_SAMPLE_W-1:0]               limitUpper,
   input  wire logic [`AOI_SAMPLE_W-1:0]               limitLower,
   // Response stream
   output logic                                        rspValid,
   output logic [`AOI_CHAN_W-1:0]                      rspChannel,
   output logic [`AOI_SAMPLE_W*(DUAL+1)-1:0]           rspData,
   output logic                                        rspSop,
   output logic                                        rspEop,
   // Threshold stream
   output logic                                        thrValid,
   output logic [`AOI_CHAN_W-1:0]                      thrChannel,
   output logic                                        thrData,
   // Control/status slave
   input  wire logic                                   csrAddress,
   input  wire logic                                   csrRead,
   input  wire logic                                   csrWrite,
   input  wire logic [`AOI_CSR_DATA_W-1:0]             csrWriteData,
   output logic [`AOI_CSR_DATA_W-1:0]                  csrReadData,
   // Interrupt
   output logic                                        irq
);

   localparam int DW = `AOI_SAMPLE_W*(DUAL+1);

   aoi_pkg::aoi_state_type          state_reg;
   logic                            lockS1_reg;
   logic                            lockS2_reg;
   logic                            doneS1_reg;
   logic                            doneS2_reg;
   logic                            doneS3_reg;
   logic [DW-1:0]                   dataS1_reg;
   logic [DW-1:0]                   dataS2_reg;
   logic [`AOI_CHAN_W-1:0]          chan_reg;
   logic                            sop_reg;
   logic                            eop_reg;
   logic                            enable_reg;
   logic                            status_reg;
   logic                            doneRise;
   logic                            cmdTake;
   logic                            isRecal;
   logic [`AOI_SAMPLE_W-1:0]        firstSample;
   logic                            eopEvent;
   logic                            statusClear;

   // Pin inputs pass two flops and convDone a third for edge detection; logic reads the second stages and that third one
   always_ff @(posedge core_clk) begin
      if (!rstN) begin  // [RULE11]
         lockS1_reg <= `AOI_SYNC_RST;
         lockS2_reg <= `AOI_SYNC_RST;
         doneS1_reg <= `AOI_SYNC_RST;
         doneS2_reg <= `AOI_SYNC_RST;
         doneS3_reg <= `AOI_SYNC_RST;
         dataS1_reg <= '0;
         dataS2_reg <= '0;
      end else if (clkEn) begin
         lockS1_reg <= pllLocked;  // [RULE13]
         lockS2_reg <= lockS1_reg;
         doneS1_reg <= convDone;
         doneS2_reg <= doneS1_reg;
         doneS3_reg <= doneS2_reg;
         dataS1_reg <= convData;
         dataS2_reg <= dataS1_reg;
      end
   end

   // Command acceptance and converter completion
   assign doneRise = doneS2_reg & ~doneS3_reg;
   assign cmdReady = (state_reg == aoi_pkg::AOI_IDLE) & lockS2_reg & clkEn;  // [RULE14]
   assign cmdTake  = cmdValid & cmdReady;  // [RULE14]
   assign isRecal  = (chan_reg == `AOI_CHAN_RECAL);
   assign firstSample = dataS2_reg[`AOI_SAMPLE_W-1:0];

   // Sequencing: idle, converting, one response cycle
   always_ff @(posedge core_clk) begin  // [RULE10]
      if (!rstN) begin
         state_reg <= aoi_pkg::AOI_IDLE;
      end else if (clkEn) begin
         unique case (state_reg)
            aoi_pkg::AOI_IDLE: begin
               if (cmdTake) begin
                  state_reg <= aoi_pkg::AOI_CONV;
               end
            end
            aoi_pkg::AOI_CONV: begin
               if (doneRise) begin
                  state_reg <= aoi_pkg::AOI_RESP;
               end
            end
            aoi_pkg::AOI_RESP: begin
               state_reg <= aoi_pkg::AOI_IDLE;
            end
            default: begin
               state_reg <= aoi_pkg::AOI_IDLE;
            end
         endcase
      end
   end

   // Command fields held for the matching result
   always_ff @(posedge core_clk) begin
      if (!rstN) begin
         chan_reg <= '0;
         sop_reg  <= 1'h0;
         eop_reg  <= 1'h0;
      end else if (clkEn && cmdTake) begin
         chan_reg <= cmdChannel;
         sop_reg  <= cmdSop;  // [RULE5]
         eop_reg  <= cmdEop;  // [RULE5]
      end
   end

   // Converter request: one-cycle start pulse with the channel held
   always_ff @(posedge core_clk) begin
      if (!rstN) begin
         convStart   <= 1'h0;
         convChannel <= '0;
      end else if (clkEn) begin
         convStart <= cmdTake;
         if (cmdTake) begin
            convChannel <= cmdChannel;
         end
      end
   end

   // Result stream, no ready: valid for one cycle per conversion, none for a recalibration
   always_ff @(posedge core_clk) begin
      if (!rstN) begin
         rspValid   <= 1'h0;
         rspChannel <= '0;
         rspData    <= '0;
         rspSop     <= 1'h0;
         rspEop     <= 1'h0;
      end else if (clkEn) begin
         rspValid <= 1'h0;
         if (state_reg == aoi_pkg::AOI_CONV && doneRise && !isRecal) begin
            rspValid   <= 1'h1;        // [RULE1]
            rspChannel <= chan_reg;    // [RULE3]
            rspData    <= dataS2_reg;  // [RULE4]
            rspSop     <= sop_reg;     // [RULE5]
            rspEop     <= eop_reg;     // [RULE5]
         end
      end
   end

   // Threshold stream: upper violation reports 1, lower reports 0
   always_ff @(posedge core_clk) begin
      if (!rstN) begin
         thrValid   <= 1'h0;
         thrChannel <= '0;
         thrData    <= 1'h0;
      end else if (clkEn) begin
         thrValid <= 1'h0;
         if (state_reg == aoi_pkg::AOI_CONV && doneRise && !isRecal) begin
            if (firstSample > limitUpper) begin
               thrValid   <= 1'h1;      // [RULE6]
               thrChannel <= chan_reg;  // [RULE6]
               thrData    <= 1'h1;      // [RULE7]
            end else if (firstSample < limitLower) begin
               thrValid   <= 1'h1;      // [RULE6]
               thrChannel <= chan_reg;  // [RULE6]
               thrData    <= 1'h0;      // [RULE7]
            end
         end
      end
   end

   // End-of-packet event and its clear; a new event wins over the clear
   assign eopEvent    = rspValid & rspEop;
   assign statusClear = csrWrite & (csrAddress == `AOI_CSR_STATUS) & csrWriteData[`AOI_BIT_EOP];

   always_ff @(posedge core_clk) begin
      if (!rstN) begin
         status_reg <= `AOI_STATUS_RST;
      end else if (clkEn) begin
         if (eopEvent) begin
            status_reg <= 1'h1;
         end else if (statusClear) begin
            status_reg <= 1'h0;
         end
      end
   end

   // Enable register write
   always_ff @(posedge core_clk) begin
      if (!rstN) begin
         enable_reg <= `AOI_ENABLE_RST;
      end else if (clkEn && csrWrite && csrAddress == `AOI_CSR_ENABLE) begin
         enable_reg <= csrWriteData[`AOI_BIT_EOP];  // [RULE8]
      end
   end

   // Read data, answered one cycle after the read
   always_ff @(posedge core_clk) begin
      if (!rstN) begin
         csrReadData <= '0;
      end else if (clkEn && csrRead) begin
         csrReadData <= '0;  // [RULE8]
         if (csrAddress == `AOI_CSR_ENABLE) begin
            csrReadData[`AOI_BIT_EOP] <= enable_reg;
         end else begin
            csrReadData[`AOI_BIT_EOP]  <= status_reg;  // [RULE15]
            csrReadData[`AOI_BIT_LOCK] <= lockS2_reg;
         end
      end
   end

   // Interrupt from status gated by enable
   always_ff @(posedge core_clk) begin
      if (!rstN) begin
         irq <= 1'h0;
      end else if (clkEn) begin
         irq <= status_reg & enable_reg;  // [RULE9] [RULE15]
      end
   end

   // Checks
   property p_take_start;
      @(posedge core_clk) disable iff (!rstN)
      (cmdValid && cmdReady) |=> (convStart && convChannel == $past(cmdChannel));
   endproperty
   a_take_start: assert property (p_take_start) else $error("start not issued after take"); // [RULE14]

   property p_ready_idle;
      @(posedge core_clk) disable iff (!rstN)
      cmdReady |-> (state_reg == aoi_pkg::AOI_IDLE && lockS2_reg);
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("ready outside idle"); // [RULE14]

   property p_rsp_pulse;
      @(posedge core_clk) disable iff (!rstN)
      (rspValid && clkEn) |=> !rspValid;
   endproperty
   a_rsp_pulse: assert property (p_rsp_pulse) else $error("response valid held too long"); // [RULE1]

   property p_rsp_cause;
      @(posedge core_clk) disable iff (!rstN)
      (state_reg == aoi_pkg::AOI_CONV && doneRise && !isRecal && clkEn) |=> rspValid;
   endproperty
   a_rsp_cause: assert property (p_rsp_cause) else $error("result not presented"); // [RULE1]

   property p_rsp_markers;
      @(posedge core_clk) disable iff (!rstN)
      rspValid |-> (rspSop == sop_reg && rspEop == eop_reg && rspChannel == chan_reg);
   endproperty
   a_rsp_markers: assert property (p_rsp_markers) else $error("markers differ from command"); // [RULE5]

   property p_thr_up;
      @(posedge core_clk) disable iff (!rstN)
      (thrValid && thrData) |-> rspValid && rspData[`AOI_SAMPLE_W-1:0] > $past(limitUpper);
   endproperty
   a_thr_up: assert property (p_thr_up) else $error("upper violation without cause"); // [RULE7]

   property p_thr_low;
      @(posedge core_clk) disable iff (!rstN)
      (thrValid && !thrData) |-> rspValid && rspData[`AOI_SAMPLE_W-1:0] < $past(limitLower);
   endproperty
   a_thr_low: assert property (p_thr_low) else $error("lower violation without cause"); // [RULE7]

   property p_thr_chan;
      @(posedge core_clk) disable iff (!rstN)
      thrValid |-> thrChannel == rspChannel;
   endproperty
   a_thr_chan: assert property (p_thr_chan) else $error("violation channel mismatch"); // [RULE6]

   property p_irq_gate;
      @(posedge core_clk) disable iff (!rstN)
      irq |-> $past(status_reg) && $past(enable_reg);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enabled status"); // [RULE15]

   property p_eop_sets;
      @(posedge core_clk) disable iff (!rstN)
      (eopEvent && clkEn) |=> status_reg;
   endproperty
   a_eop_sets: assert property (p_eop_sets) else $error("end of packet event lost"); // [RULE9]

   c_result: cover property (@(posedge core_clk) disable iff (!rstN) rspValid && rspEop);
   c_thr_up: cover property (@(posedge core_clk) disable iff (!rstN) thrValid && thrData);
   c_thr_low: cover property (@(posedge core_clk) disable iff (!rstN) thrValid && !thrData);
   c_irq: cover property (@(posedge core_clk) disable iff (!rstN) irq);

endmodule : aoi_adc_core_if
`default_nettype wire

//--- verification/aoi_conv_model.sv
// Behavioural model of the hard converter that answers the control core
`timescale 1ns/1ns
`default_nettype none
module aoi_conv_model (
   input  wire logic        core_clk,
   input  wire logic        convStart,
   input  wire logic [3:0]  delayIn,
   input  wire logic [11:0] sampleIn,
   output logic             convDone,
   output logic [11:0]      convData
);
   int count = -1;
   int hold  = 0;
   initial convDone = 1'b0;
   initial convData = 12'h0000;
   // Converts after a chosen delay, then keeps the sample only while it is needed
   always @(posedge core_clk) begin
      if (hold > 0) begin
         hold <= hold - 1;
      end
      if (hold == 1) begin
         convData <= ~convData; // Stale sample is not left standing
      end
      // A new start overrides the stale-sample flip of the previous one
      if (convStart) begin
         convDone <= 1'b0;
         convData <= sampleIn;
         count    <= delayIn;
         hold     <= 0;
      end else if (count > 0) begin
         count <= count - 1;
      end else if (count == 0) begin
         convDone <= 1'b1;
         count    <= -1;
         hold     <= 8;
      end
   end
endmodule : aoi_conv_model
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the converter control core
`timescale 1ns/1ns
`default_nettype none
`include "aoi_adc_map.svh"
module testbench;
   logic        core_clk = 1'b0;
   logic        rstN = 1'b0;
   logic        clkEn = 1'b1;
   logic        cmdValid = 1'b0;
   logic        cmdReady;
   logic [4:0]  cmdChannel = 5'h00;
   logic        cmdSop = 1'b0;
   logic        cmdEop = 1'b0;
   logic        pllLocked = 1'b0;
   logic        convStart;
   logic [4:0]  convChannel;
   logic        convDone;
   logic [11:0] convData;
   logic [3:0]  delayIn = 4'h2;
   logic [11:0] sampleIn = 12'h0000;
   logic [11:0] limitUpper = 12'h0C00;
   logic [11:0] limitLower = 12'h0100;
   logic        rspValid;
   logic [4:0]  rspChannel;
   logic [11:0] rspData;
   logic        rspSop;
   logic        rspEop;
   logic        thrValid;
   logic [4:0]  thrChannel;
   logic        thrData;
   logic        csrAddress = 1'b0;
   logic        csrRead = 1'b0;
   logic        csrWrite = 1'b0;
   logic [31:0] csrWriteData = 32'h0000_0000;
   logic [31:0] csrReadData;
   logic        irq;
   int          miscompares = 0;
   int          checks = 0;
   always #10 core_clk = ~core_clk;
   aoi_adc_core_if #(.DUAL(0)) u_dut (.core_clk(core_clk), .rstN(rstN), .clkEn(clkEn), .cmdValid(cmdValid),
      .cmdReady(cmdReady), .cmdChannel(cmdChannel), .cmdSop(cmdSop), .cmdEop(cmdEop), .pllLocked(pllLocked),
      .convStart(convStart), .convChannel(convChannel), .convDone(convDone), .convData(convData),
      .limitUpper(limitUpper), .limitLower(limitLower), .rspValid(rspValid), .rspChannel(rspChannel),
      .rspData(rspData), .rspSop(rspSop), .rspEop(rspEop), .thrValid(thrValid), .thrChannel(thrChannel),
      .thrData(thrData), .csrAddress(csrAddress), .csrRead(csrRead), .csrWrite(csrWrite),
      .csrWriteData(csrWriteData), .csrReadData(csrReadData), .irq(irq));
   aoi_conv_model u_conv (.core_clk(core_clk), .convStart(convStart), .delayIn(delayIn), .sampleIn(sampleIn),
      .convDone(convDone), .convData(convData));
   // Prints the counts and the verdict, then stops
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // Compares one value and counts the outcome
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // One command, its conversion, and the result and threshold streams
   task automatic convert(input logic [4:0] ch, input logic sop, input logic eop, input logic [11:0] smp,
                          input logic [3:0] dly, input logic thr, input logic dir);
      int n;
      n = 0;
      @(posedge core_clk);
      cmdValid   <= 1'b1;
      cmdChannel <= ch;
      cmdSop     <= sop;
      cmdEop     <= eop;
      sampleIn   <= smp;
      delayIn    <= dly;
      do begin
         @(posedge core_clk);
         n++;
      end while (cmdReady !== 1'b1 && n < 50);
      if (cmdReady !== 1'b1) begin
         chk(1'h0, 1'h1, "ready timeout");
         end_of_test();
      end
      cmdValid <= 1'b0;
      @(posedge core_clk);
      chk(convStart, 1'h1, "start");
      chk(convChannel, ch, "conv channel");
      chk(cmdReady, 1'h0, "busy ready");
      n = 0;
      // Sink looks at the result stream every cycle, so no result can pass unseen
      while (rspValid !== 1'b1 && n < 40) begin
         @(posedge core_clk);
         n++;
      end
      if (ch == `AOI_CHAN_RECAL) begin
         chk(rspValid, 1'h0, "recal response");
         return;
      end
      if (n >= 40) begin
         chk(1'h0, 1'h1, "response timeout");
         end_of_test();
      end
      chk(rspChannel, ch, "rsp channel");
      chk(rspData, smp, "rsp data");
      chk({rspSop, rspEop}, {sop, eop}, "markers");
      chk(thrValid, thr, "thr valid");
      if (thr) chk({thrChannel, thrData}, {ch, dir}, "thr fields");
   endtask : convert
   // Control/status write and read
   task automatic csrWr(input logic a, input logic [31:0] d);
      @(posedge core_clk);
      csrWrite     <= 1'b1;
      csrAddress   <= a;
      csrWriteData <= d;
      @(posedge core_clk);
      csrWrite <= 1'b0;
   endtask : csrWr
   task automatic csrRd(input logic a, input logic [31:0] exp);
      @(posedge core_clk);
      csrRead    <= 1'b1;
      csrAddress <= a;
      @(posedge core_clk);
      csrRead <= 1'b0;
      @(posedge core_clk);
      chk(csrReadData, exp, "csr read");
   endtask : csrRd
   // Unlocked core refuses commands until the lock has passed its synchroniser
   task automatic test_lock;
      repeat (4) @(posedge core_clk);
      chk(cmdReady, 1'h0, "unlocked ready");
      pllLocked <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk(cmdReady, 1'h1, "locked ready");
      clkEn <= 1'b0;
      @(posedge core_clk);
      chk(cmdReady, 1'h0, "frozen ready");
      clkEn <= 1'b1;
      @(posedge core_clk);
      $display("test lock done");
   endtask : test_lock
   // Limit violations above and below, an in-range sample and a recalibration
   task automatic test_stream;
      convert(5'h00, 1'b1, 1'b0, 12'h0FFF, 4'h0, 1'b1, 1'b1);
      convert(`AOI_CHAN_TSD, 1'b0, 1'b0, 12'h0050, 4'h9, 1'b1, 1'b0);
      convert(5'h10, 1'b0, 1'b1, 12'h0A5C, 4'h3, 1'b0, 1'b0);
      convert(`AOI_CHAN_RECAL, 1'b1, 1'b1, 12'h0123, 4'h1, 1'b0, 1'b0);
      $display("test stream done");
   endtask : test_stream
   // End-of-packet event raises the interrupt and a status write clears it; masking keeps status visible
   task automatic test_irq;
      csrRd(`AOI_CSR_ENABLE, 32'h0000_0000);
      csrWr(`AOI_CSR_ENABLE, 32'h0000_0001);
      csrRd(`AOI_CSR_ENABLE, 32'h0000_0001);
      convert(5'h05, 1'b1, 1'b1, 12'h0400, 4'h2, 1'b0, 1'b0);
      repeat (3) @(posedge core_clk);
      chk(irq, 1'h1, "irq raised");
      csrRd(`AOI_CSR_STATUS, 32'h0000_0003);
      csrWr(`AOI_CSR_STATUS, 32'h0000_0001);
      repeat (3) @(posedge core_clk);
      chk(irq, 1'h0, "irq cleared");
      csrWr(`AOI_CSR_ENABLE, 32'h0000_0000);
      convert(5'h06, 1'b0, 1'b1, 12'h0400, 4'h2, 1'b0, 1'b0);
      repeat (3) @(posedge core_clk);
      chk(irq, 1'h0, "irq masked");
      csrRd(`AOI_CSR_STATUS, 32'h0000_0003);
      $display("test irq done");
   endtask : test_irq
   // Main sequence
   initial begin
      repeat (3) @(posedge core_clk);
      chk({rspValid, thrValid, convStart, irq}, 4'h0, "reset outputs");
      rstN <= 1'b1;
      test_lock();
      test_stream();
      test_irq();
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
